// ===== rtl/ttdma_pkg.sv
// Package of constants and types for the two-channel DMA controller
package ttdma_pkg;
  localparam int NCH = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PTR_W = 20;
  localparam int CNT_W = 16;
  localparam int MEM_W = 16;
  localparam int NCAUSE = 16;
  // Per-channel register offsets; channel 1 adds the stride
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_CON = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_DST = 8'h0C;
  localparam logic [7:0] OFS_RLD = 8'h10;
  localparam logic [7:0] OFS_CNT = 8'h14;
  localparam logic [7:0] OFS_PTR = 8'h18;
  localparam logic [7:0] OFS_STRIDE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  // request_select_reg fields
  localparam int SEL_CAUSE_LO = 0;
  localparam int SEL_CAUSE_HI = 3;
  localparam int SEL_EXT = 4;
  localparam int SEL_SWREQ = 5;
  // channel_control_reg fields
  localparam int CON_EN = 0;
  localparam int CON_PEND = 1;
  localparam int CON_WORD = 2;
  localparam int CON_RPT = 3;
  localparam int CON_SINC = 4;
  localparam int CON_DINC = 5;
  // Cause codes with special meaning
  localparam logic [3:0] CAUSE_PIN_FALL = 4'h0;
  localparam logic [3:0] CAUSE_SW = 4'h1;
  localparam logic [3:0] CAUSE_PIN_BOTH = 4'h7;
  localparam logic [PTR_W-1:0] STEP_BYTE = 20'h00001;
  localparam logic [PTR_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_CAPT = 4'h4,
    ST_WRITE = 4'h8
  } ttdma_state_t;
endpackage

// ===== rtl/ttdma_top.sv
// Two-channel cycle-stealing DMA controller with register port
`timescale 1ns/1ps
module ttdma_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ttdma_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ttdma_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ttdma_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [ttdma_pkg::NCAUSE-1:0] periph_req_i,
  input wire logic ext_irq_pin_0_i,
  input wire logic ext_irq_pin_1_i,
  output logic bus_own_o,
  output logic [ttdma_pkg::PTR_W-1:0] mem_addr_o,
  output logic [ttdma_pkg::MEM_W-1:0] mem_wdata_o,
  output logic mem_word_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  input wire logic [ttdma_pkg::MEM_W-1:0] mem_rdata_i,
  output logic irq_o
);
  import ttdma_pkg::*;

  // Address match for a channel register, used by writes and reads
  function automatic logic reg_hit(input logic [7:0] a, input int ch,
                                   input logic [7:0] ofs);
    return a == (ofs + ((ch != 0) ? OFS_STRIDE : 8'h00));
  endfunction

  logic [NCH-1:0] en_reg, pend_reg, word_reg, rpt_reg, sinc_reg, dinc_reg;
  logic [NCH-1:0] ext_reg, first_reg;
  logic [3:0] cause_reg [NCH];
  logic [PTR_W-1:0] src_reg [NCH];
  logic [PTR_W-1:0] dst_reg [NCH];
  logic [PTR_W-1:0] wptr_reg [NCH];
  logic [CNT_W-1:0] rld_reg [NCH];
  logic [CNT_W-1:0] cnt_reg [NCH];
  logic [PTR_W-1:0] src_addr [NCH];
  logic [PTR_W-1:0] dst_addr [NCH];
  logic [NCH-1:0] req_hit, ready, gnt, done, uflow;
  logic [NCH-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_fall, pin_both;
  logic [NCH-1:0] irq_stat_reg, irq_mask_reg;
  logic [DATA_W-1:0] rdata_next;
  logic sel_reg;
  ttdma_state_t state_reg;

  // Two-stage sync of the external pins; third stage only feeds edge detect
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {ext_irq_pin_1_i, ext_irq_pin_0_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  assign pin_fall = pin_s3_reg & ~pin_s2_reg;
  assign pin_both = pin_s3_reg ^ pin_s2_reg;

  // Channel 0 always beats channel 1; grants only from idle
  assign ready = pend_reg & en_reg;
  assign gnt[0] = (state_reg == ST_IDLE) && ready[0];
  assign gnt[1] = (state_reg == ST_IDLE) && ready[1] && !ready[0];

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic wr_sel, wr_con, wr_src, wr_dst, wr_rld;
      logic [PTR_W-1:0] cur_ptr, step;
      assign wr_sel = reg_wr_i && reg_hit(reg_addr_i, i, OFS_SEL);
      assign wr_con = reg_wr_i && reg_hit(reg_addr_i, i, OFS_CON);
      assign wr_src = reg_wr_i && reg_hit(reg_addr_i, i, OFS_SRC);
      assign wr_dst = reg_wr_i && reg_hit(reg_addr_i, i, OFS_DST);
      assign wr_rld = reg_wr_i && reg_hit(reg_addr_i, i, OFS_RLD);
      assign done[i] = (state_reg == ST_WRITE) && (sel_reg == 1'(i));
      assign uflow[i] = done[i] && (cnt_reg[i] == CNT_ZERO);
      assign step = word_reg[i] ? STEP_WORD : STEP_BYTE;
      // First run after enable takes the programmed pointer
      assign cur_ptr = first_reg[i] ? (sinc_reg[i] ? src_reg[i] : dst_reg[i])
                                    : wptr_reg[i];
      // Source wins if software wrongly sets both directions
      assign src_addr[i] = sinc_reg[i] ? cur_ptr : src_reg[i];
      assign dst_addr[i] = (dinc_reg[i] && !sinc_reg[i]) ? cur_ptr
                                                         : dst_reg[i];

      // Request decode; interrupt mask and priority levels play no part
      always_comb begin
        req_hit[i] = wr_sel && reg_wdata_i[SEL_SWREQ];
        if (ext_reg[i]) begin
          if (cause_reg[i] == CAUSE_PIN_BOTH) begin
            req_hit[i] = req_hit[i] || pin_both[i];
          end
        end else if (cause_reg[i] == CAUSE_PIN_FALL) begin
          req_hit[i] = req_hit[i] || pin_fall[i];
        end else if (cause_reg[i] != CAUSE_SW) begin
          req_hit[i] = req_hit[i] || periph_req_i[cause_reg[i]];
        end
      end

      // Pending flag: one bit, so back-to-back requests merge
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pend_reg[i] <= 1'b0;
        end else if (req_hit[i] && en_reg[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (gnt[i]) begin
          pend_reg[i] <= 1'b0;
        end else if (wr_con && !reg_wdata_i[CON_PEND]) begin
          pend_reg[i] <= 1'b0;
        end
      end

      // Control bits; single-mode underflow drops the enable
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          en_reg[i] <= 1'b0;
          word_reg[i] <= 1'b0;
          rpt_reg[i] <= 1'b0;
          sinc_reg[i] <= 1'b0;
          dinc_reg[i] <= 1'b0;
          first_reg[i] <= 1'b0;
        end else begin
          if (wr_con) begin
            en_reg[i] <= reg_wdata_i[CON_EN];
            word_reg[i] <= reg_wdata_i[CON_WORD];
            rpt_reg[i] <= reg_wdata_i[CON_RPT];
            sinc_reg[i] <= reg_wdata_i[CON_SINC];
            dinc_reg[i] <= reg_wdata_i[CON_DINC];
          end else if (uflow[i] && !rpt_reg[i]) begin
            en_reg[i] <= 1'b0;
          end
          if (wr_con && reg_wdata_i[CON_EN] && !en_reg[i]) begin
            first_reg[i] <= 1'b1;
          end else if (gnt[i]) begin
            first_reg[i] <= 1'b0;
          end
        end
      end

      // Software-programmed selection, pointers and reload value
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cause_reg[i] <= 4'h0;
          ext_reg[i] <= 1'b0;
          src_reg[i] <= '0;
          dst_reg[i] <= '0;
          rld_reg[i] <= '0;
        end else begin
          if (wr_sel) begin
            cause_reg[i] <= reg_wdata_i[SEL_CAUSE_HI:SEL_CAUSE_LO];
            ext_reg[i] <= reg_wdata_i[SEL_EXT];
          end
          if (wr_src) begin
            src_reg[i] <= reg_wdata_i[PTR_W-1:0];
          end
          if (wr_dst) begin
            dst_reg[i] <= reg_wdata_i[PTR_W-1:0];
          end
          if (wr_rld) begin
            rld_reg[i] <= reg_wdata_i[CNT_W-1:0];
          end
        end
      end

      // Working pointer and counter; N+1 transfers per reload value N
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          wptr_reg[i] <= '0;
          cnt_reg[i] <= '0;
        end else if (gnt[i] && first_reg[i]) begin
          wptr_reg[i] <= cur_ptr;
          cnt_reg[i] <= rld_reg[i];
        end else if (done[i]) begin
          if (sinc_reg[i] || dinc_reg[i]) begin
            wptr_reg[i] <= wptr_reg[i] + step;
          end
          if (uflow[i]) begin
            cnt_reg[i] <= rpt_reg[i] ? rld_reg[i] : CNT_ZERO;
          end else begin
            cnt_reg[i] <= cnt_reg[i] - CNT_ONE;
          end
        end
      end

      a_pend_on_grant: assert property (@(posedge core_clk_i) disable iff (rst_i)
        gnt[i] && !(req_hit[i] && en_reg[i]) |=> !pend_reg[i])
        else $error("pending not cleared on grant");
      a_single_halts: assert property (@(posedge core_clk_i) disable iff (rst_i)
        uflow[i] && !rpt_reg[i] && !wr_con |=> !en_reg[i] ##1 !gnt[i])
        else $error("single run kept enable");
      a_repeat_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
        uflow[i] && rpt_reg[i] && !wr_rld |=> cnt_reg[i] == rld_reg[i])
        else $error("repeat counter not reloaded");
      a_uflow_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        uflow[i] |=> irq_stat_reg[i] ##1 (irq_o || !$past(irq_mask_reg[i])))
        else $error("underflow did not flag interrupt");
      a_pend_w1_kept: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pend_reg[i] && wr_con && reg_wdata_i[CON_PEND] && !gnt[i]
        |=> pend_reg[i])
        else $error("writing one cleared pending");
      a_disable_blocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !en_reg[i] && !pend_reg[i] |=> !pend_reg[i])
        else $error("disabled channel granted");
    end
  endgenerate

  // Transfer sequencer; owns the bus for read, capture and write
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      sel_reg <= 1'b0;
      bus_own_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      mem_word_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // CPU is held off at once by the bus ownership level
          if (|gnt) begin
            sel_reg <= gnt[1];
            bus_own_o <= 1'b1;
            mem_addr_o <= gnt[1] ? src_addr[1] : src_addr[0];
            mem_word_o <= gnt[1] ? word_reg[1] : word_reg[0];
            mem_rd_o <= 1'b1;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          mem_rd_o <= 1'b0;
          state_reg <= ST_CAPT;
        end
        ST_CAPT: begin
          // Read data is valid the cycle after the read strobe
          mem_wdata_o <= mem_rdata_i;
          mem_addr_o <= dst_addr[sel_reg];
          mem_wr_o <= 1'b1;
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          mem_wr_o <= 1'b0;
          bus_own_o <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          mem_rd_o <= 1'b0;
          mem_wr_o <= 1'b0;
          bus_own_o <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  a_read_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_rd_o) |-> bus_own_o ##1 !mem_rd_o ##1 mem_wr_o ##1 !mem_wr_o)
    else $error("transfer not one read then one write");
  a_bus_priority: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mem_rd_o || mem_wr_o) |-> bus_own_o)
    else $error("bus cycle without ownership");
  a_ch0_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_IDLE && ready[0] |=> mem_rd_o && !sel_reg)
    else $error("channel 0 not served first");
  a_wdata_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_CAPT |=> mem_wdata_o == $past(mem_rdata_i))
    else $error("write data differs from read data");

  // Interrupt status: set beats a write-one clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata_i[NCH-1:0]) | uflow;
      end else begin
        irq_stat_reg <= irq_stat_reg | uflow;
      end
      if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata_i[NCH-1:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_next = '0;
    for (int c = 0; c < NCH; c++) begin
      if (reg_hit(reg_addr_i, c, OFS_SEL)) begin
        rdata_next[SEL_CAUSE_HI:SEL_CAUSE_LO] = cause_reg[c];
        rdata_next[SEL_EXT] = ext_reg[c];
      end
      if (reg_hit(reg_addr_i, c, OFS_CON)) begin
        rdata_next[CON_EN] = en_reg[c];
        rdata_next[CON_PEND] = pend_reg[c];
        rdata_next[CON_WORD] = word_reg[c];
        rdata_next[CON_RPT] = rpt_reg[c];
        rdata_next[CON_SINC] = sinc_reg[c];
        rdata_next[CON_DINC] = dinc_reg[c];
      end
      if (reg_hit(reg_addr_i, c, OFS_SRC)) rdata_next[PTR_W-1:0] = src_reg[c];
      if (reg_hit(reg_addr_i, c, OFS_DST)) rdata_next[PTR_W-1:0] = dst_reg[c];
      if (reg_hit(reg_addr_i, c, OFS_RLD)) rdata_next[CNT_W-1:0] = rld_reg[c];
      if (reg_hit(reg_addr_i, c, OFS_CNT)) rdata_next[CNT_W-1:0] = cnt_reg[c];
      if (reg_hit(reg_addr_i, c, OFS_PTR)) rdata_next[PTR_W-1:0] = wptr_reg[c];
    end
    if (reg_addr_i == OFS_IRQ_STAT) rdata_next[NCH-1:0] = irq_stat_reg;
    if (reg_addr_i == OFS_IRQ_MASK) rdata_next[NCH-1:0] = irq_mask_reg;
  end

  // Read data shows only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_next : '0;
    end
  end
  // The source's own interrupt flag has no path from this block
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the two-channel DMA controller
`timescale 1ns/1ps
module tb;
  import ttdma_pkg::*;
  localparam logic [31:0] EN = 32'h1 << CON_EN;
  localparam logic [31:0] PEND = 32'h1 << CON_PEND;
  localparam logic [31:0] WORD = 32'h1 << CON_WORD;
  localparam logic [31:0] RPT = 32'h1 << CON_RPT;
  localparam logic [31:0] SINC = 32'h1 << CON_SINC;
  localparam logic [31:0] DINC = 32'h1 << CON_DINC;
  localparam logic [31:0] SWR = 32'h1 << SEL_SWREQ;
  logic core_clk_i;
  logic rst_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [NCAUSE-1:0] periph_req_i;
  logic ext_irq_pin_0_i;
  logic ext_irq_pin_1_i;
  logic bus_own_o;
  logic [PTR_W-1:0] mem_addr_o;
  logic [MEM_W-1:0] mem_wdata_o;
  logic mem_word_o;
  logic mem_rd_o;
  logic mem_wr_o;
  logic [MEM_W-1:0] mem_rdata_i;
  logic irq_o;
  int error_cnt = 0;
  int checks = 0;
  logic [37:0] log_q[$];

  ttdma_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .periph_req_i(periph_req_i),
    .ext_irq_pin_0_i(ext_irq_pin_0_i), .ext_irq_pin_1_i(ext_irq_pin_1_i),
    .bus_own_o(bus_own_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_word_o(mem_word_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));
  ttdma_mem_model mem (.core_clk_i(core_clk_i), .rst_i(rst_i), .mem_addr_i(mem_addr_o),
    .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i));

  // Clock at 40 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Log destination writes mid-cycle, away from the launching edge
  always @(negedge core_clk_i) begin
    if (mem_wr_o === 1'b1) begin
      log_q.push_back({bus_own_o, mem_word_o, mem_addr_o, mem_wdata_o});
    end
  end

  function automatic logic [7:0] ofs(input int ch, input logic [7:0] o);
    return o + ((ch == 1) ? OFS_STRIDE : 8'h00);
  endfunction

  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(38'(reg_rdata_o), 38'(exp));
    @(posedge core_clk_i);
  endtask

  task automatic pulse(input logic [3:0] c);
    periph_req_i <= 16'h0001 << c;
    @(posedge core_clk_i);
    periph_req_i <= 16'h0000;
    @(posedge core_clk_i);
  endtask

  // Bounded wait for the n-th destination write
  task automatic wait_n(input int n);
    for (int i = 0; i < 40 && log_q.size() < n; i++) @(posedge core_clk_i);
    if (log_q.size() < n) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, log_q.size(), n);
      give_verdict();
    end
  endtask

  task automatic idle(input int n);
    repeat (12) @(posedge core_clk_i);
    check(38'(log_q.size()), 38'(n));
  endtask

  // Byte units compare only the low lane of the write data
  task automatic chk_wr(input int k, input logic w, input logic [PTR_W-1:0] a,
                        input logic [PTR_W-1:0] s);
    logic [37:0] got;
    logic [15:0] pat;
    got = log_q[k];
    pat = s[15:0] ^ 16'hA5C3;
    if (!w) begin
      got[15:8] = 8'h00;
      pat[15:8] = 8'h00;
    end
    check(got, {1'b1, w, a, pat});
  endtask

  initial begin
    logic [PTR_W-1:0] s0, d0, s1, d1;
    logic [CNT_W-1:0] n;
    logic [3:0] c;
    int b;
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    periph_req_i = 16'h0000;
    ext_irq_pin_0_i = 1'b0;
    ext_irq_pin_1_i = 1'b0;
    void'($urandom(32'h464e));
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd_chk(ofs(0, OFS_CON), 32'h0);
    rd_chk(8'hFC, 32'h0);
    s0 = PTR_W'($urandom) & 20'hFFFFE;
    d0 = PTR_W'($urandom) & 20'hFFF00;
    n = CNT_W'(2 + $urandom % 3);
    wr(ofs(0, OFS_SRC), 32'(s0));
    wr(ofs(0, OFS_DST), 32'(d0));
    wr(ofs(0, OFS_RLD), 32'(n));
    wr(ofs(0, OFS_SEL), SWR);
    idle(0);
    wr(OFS_IRQ_MASK, 32'h3);
    wr(ofs(0, OFS_CON), EN | DINC);
    // Single byte run, destination stepping by one
    for (int k = 0; k <= int'(n); k++) begin
      wr(ofs(0, OFS_SEL), SWR);
      wait_n(k + 1);
      chk_wr(k, 1'b0, d0 + PTR_W'(k), s0);
      if (k == 0) rd_chk(ofs(0, OFS_CNT), 32'(n - 1));
    end
    repeat (4) @(posedge core_clk_i);
    check(38'(irq_o), 38'h1);
    rd_chk(OFS_IRQ_STAT, 32'h1);
    wr(ofs(0, OFS_SEL), SWR);
    idle(int'(n) + 1);
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (3) @(posedge core_clk_i);
    check(38'(irq_o), 38'h0);
    // Repeat word run on channel 1 from a peripheral cause, interrupt masked
    b = log_q.size();
    c = 4'(2 + $urandom % 14);
    s1 = PTR_W'($urandom) & 20'hFFFF0;
    d1 = PTR_W'($urandom) & 20'hFFFFE;
    wr(ofs(1, OFS_SRC), 32'(s1));
    wr(ofs(1, OFS_DST), 32'(d1));
    wr(ofs(1, OFS_RLD), 32'h1);
    wr(ofs(1, OFS_SEL), 32'(c));
    wr(OFS_IRQ_MASK, 32'h1);
    wr(ofs(1, OFS_CON), EN | RPT | WORD | SINC);
    for (int k = 0; k < 3; k++) begin
      pulse(c);
      wait_n(b + k + 1);
      chk_wr(b + k, 1'b1, d1, s1 + PTR_W'(2 * k));
    end
    rd_chk(OFS_IRQ_STAT, 32'h2);
    check(38'(irq_o), 38'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    repeat (3) @(posedge core_clk_i);
    check(38'(irq_o), 38'h1);
    wr(OFS_IRQ_STAT, 32'h2);
    // Both channels asked by one pulse: channel 0 goes first
    b = log_q.size();
    wr(ofs(0, OFS_SEL), 32'(c));
    wr(ofs(0, OFS_CON), EN | RPT);
    pulse(c);
    wait_n(b + 2);
    chk_wr(b, 1'b0, d0, s0);
    chk_wr(b + 1, 1'b1, d1, s1 + 20'h00006);
    wr(ofs(1, OFS_CON), 32'h0);
    pulse(c);
    wait_n(b + 3);
    idle(b + 3);
    chk_wr(b + 2, 1'b0, d0, s0);
    wr(ofs(0, OFS_CON), EN | RPT | PEND);
    idle(b + 3);
    rd_chk(ofs(0, OFS_CON), EN | RPT);
    // Second request waits while the first is on the bus; writing zero drops it
    wr(ofs(0, OFS_SEL), SWR);
    wr(ofs(0, OFS_SEL), SWR);
    wr(ofs(0, OFS_CON), EN | RPT);
    idle(b + 4);
    // Writing one leaves the waiting request in place
    wr(ofs(0, OFS_SEL), SWR);
    wr(ofs(0, OFS_SEL), SWR);
    wr(ofs(0, OFS_CON), EN | RPT | PEND);
    idle(b + 6);
    // Pin causes: falling edge, then a rising edge with both edges chosen
    wr(ofs(0, OFS_SEL), 32'(CAUSE_PIN_FALL));
    ext_irq_pin_0_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    ext_irq_pin_0_i <= 1'b0;
    wait_n(b + 7);
    chk_wr(b + 6, 1'b0, d0, s0);
    wr(ofs(0, OFS_SEL), (32'h1 << SEL_EXT) | 32'(CAUSE_PIN_BOTH));
    ext_irq_pin_0_i <= 1'b1;
    wait_n(b + 8);
    chk_wr(b + 7, 1'b0, d0, s0);
    give_verdict();
  end
endmodule

// ===== testbench/ttdma_mem_model.sv
// Memory model that answers the read cycles of the DMA controller
`timescale 1ns/1ps
module ttdma_mem_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ttdma_pkg::PTR_W-1:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic [ttdma_pkg::MEM_W-1:0] mem_rdata_o
);
  import ttdma_pkg::*;
  logic [MEM_W-1:0] held_reg;

  // Data from the address only in the cycle after a read strobe
  // Afterwards it flips every cycle, so a sample one cycle late never matches
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_reg <= 16'h0000;
    end else if (mem_rd_i) begin
      held_reg <= mem_addr_i[15:0] ^ 16'hA5C3;
    end else begin
      held_reg <= ~held_reg;
    end
  end
  assign mem_rdata_o = held_reg;
endmodule
